// ==== i2c_master_model.sv ====
// bus master model: drives scl and sda as open-drain releases
// assumes pulled-up wires resolved by the bench and fed back here
`timescale 1ns/1ps
module i2c_master_model (
    output logic scl_drv,
    output logic sda_drv,
    output logic stalled,
    input wire logic scl_wire,
    input wire logic sda_wire
);
    // ****************************************
    // bit and frame tasks
    // ****************************************
    localparam realtime HALF = 62.5;
    initial begin
        scl_drv = 1'h1;
        sda_drv = 1'h1;
        stalled = 1'h0;
    end
    // the slave may stretch scl, so the wait for high is bounded
    task automatic rise();
        scl_drv = 1'h1;
        for (int i = 0; i < 4000 && scl_wire !== 1'h1; i++) #10;
        if (scl_wire !== 1'h1) stalled = 1'h1;
    endtask
    // sda only moves mid-low, away from both scl edges
    task automatic bit_io(input logic b, output logic v);
        #(HALF / 2) sda_drv = b;
        #(HALF / 2) rise();
        #(HALF / 2) v = sda_wire;
        #(HALF / 2) scl_drv = 1'h0;
    endtask
    // also a repeated start when entered with scl low
    task automatic start();
        #(HALF / 2) sda_drv = 1'h1;
        #(HALF / 2) rise();
        #(HALF / 2) sda_drv = 1'h0;
        #(HALF / 2) scl_drv = 1'h0;
    endtask
    task automatic stop();
        #(HALF / 2) sda_drv = 1'h0;
        #(HALF / 2) rise();
        #(HALF) sda_drv = 1'h1;
    endtask
    task automatic idle_clocks(input int n);
        repeat (n) begin
            #(HALF) scl_drv = 1'h0;
            #(HALF) rise();
        end
    endtask
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic v;
        for (int i = 7; i >= 0; i--) bit_io(d[i], v);
        bit_io(1'h1, v);
        ack = ~v;
    endtask
    task automatic read_byte(input logic ack_in, output logic [7:0] d);
        logic v;
        for (int i = 7; i >= 0; i--) bit_io(1'h1, d[i]);
        bit_io(~ack_in, v);
    endtask
endmodule

// ==== i2c_slave_address_match.sv ====
// two-wire bus slave: address match, byte receive and byte transmit with clock stretching
// assumes an external master drives scl_clk; open-drain wires are resolved outside
`timescale 1ns/1ps
module i2c_slave_address_match (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic scl_clk,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic module_enable_bit,
    input wire logic ten_bit_address_mode,
    input wire logic [i2c_slave_pkg::ADDR_W-1:0] slave_address_reg,
    input wire logic [i2c_slave_pkg::DATA_W-1:0] transmit_holding_reg,
    input wire logic transmit_write,
    input wire logic clock_release_bit,
    output logic [i2c_slave_pkg::DATA_W-1:0] receive_buffer,
    input wire logic receive_buffer_read,
    output logic receive_buffer_full,
    output logic receive_overflow_flag,
    input wire logic overflow_clear,
    output logic slave_event_flag,
    output logic ten_bit_match_flag,
    output logic clock_held
);
    import i2c_slave_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    link_state_e state;
    link_state_e next_state;
    logic next_ten_match;
    logic [CNT_W-1:0] bit_cnt;
    logic [DATA_W-1:0] shift;
    logic start_tog;
    logic start_seen;
    logic ten_match;
    logic nine_done;
    logic nine_event;
    logic sda_drive;
    logic tx_lead;
    logic hold_tog;
    logic event_tog;
    logic rx_tog;
    logic [DATA_W-1:0] rx_hold;
    logic cfg_en;
    logic cfg_mode;
    logic [ADDR_W-1:0] cfg_addr;
    logic cfg_rbf;
    logic cfg_ov;
    logic hold_s;
    logic hold_prev;
    logic rel_tog;
    logic event_p;
    logic rx_p;
    logic [DATA_W-1:0] tx_buf;
    logic [DATA_W-1:0] tx_word;
    logic tx_full;
    logic clock_release;

    // ************************************************************
    // crossings
    // ************************************************************
    level_sync #(.WIDTH(CFG_W)) u_cfg_sync (
        .clk(scl_clk),
        .arst_n(arst_n),
        .d({module_enable_bit, ten_bit_address_mode, slave_address_reg, receive_buffer_full, receive_overflow_flag}),
        .q({cfg_en, cfg_mode, cfg_addr, cfg_rbf, cfg_ov})
    );

    level_sync #(.WIDTH(2)) u_stat_sync (
        .clk(mclk),
        .arst_n(arst_n),
        .d({hold_tog, ten_match}),
        .q({hold_s, ten_bit_match_flag})
    );

    toggle_pulse #(.WIDTH(2)) u_evt_sync (
        .clk(mclk),
        .arst_n(arst_n),
        .tog({event_tog, rx_tog}),
        .pulse({event_p, rx_p})
    );

    // ************************************************************
    // start detection
    // ************************************************************
    // sda falling while scl high; the first rising scl edge after it carries the msb
    always_ff @(negedge sda_in or negedge arst_n) begin
        if (!arst_n) begin
            start_tog <= 1'b0;
        end else if (scl_clk) begin
            start_tog <= ~start_tog;
        end
    end

    // ************************************************************
    // address decode
    // ************************************************************
    wire new_frame = (start_tog != start_seen) && cfg_en;
    wire byte_end = (bit_cnt == BYTE_BITS);
    wire dir_read = shift[0];
    wire match7 = (shift[7:1] == cfg_addr[6:0]);
    wire match_hi = (shift[7:3] == TEN_BIT_PREFIX) && (shift[2:1] == cfg_addr[9:8]);
    wire match_lo = (shift == cfg_addr[7:0]);
    wire hit_first = cfg_mode ? (match_hi && (!dir_read || ten_match)) : match7;
    wire addr_hit = ((state == ST_ADDR) && hit_first) || ((state == ST_ADDR2) && match_lo);
    // stale by two scl edges; software must not race a byte in flight
    wire rx_ack = !cfg_rbf && !cfg_ov;
    wire rx_state = (state == ST_RX);
    wire tx_state = (state == ST_TX);
    wire [2:0] tx_idx = MSB_IDX - bit_cnt[2:0];

    // ************************************************************
    // link state machine
    // ************************************************************
    always_comb begin
        next_state = state;
        next_ten_match = ten_match;
        if (!cfg_en) begin
            next_state = ST_IDLE;
        end else if (new_frame) begin
            next_state = ST_ADDR;
        end else begin
            case (state)
                ST_IDLE, ST_RX: begin
                    next_state = state;
                end
                ST_ADDR: begin
                    if (byte_end && cfg_mode) begin
                        if (match_hi && !dir_read) begin
                            next_state = ST_ADDR2;
                            next_ten_match = 1'b0;
                        end else if (match_hi && ten_match) begin
                            next_state = ST_TX;
                        end else begin
                            next_state = ST_IDLE;
                            next_ten_match = 1'b0;
                        end
                    end else if (byte_end) begin
                        next_state = match7 ? (dir_read ? ST_TX : ST_RX) : ST_IDLE;
                    end
                end
                ST_ADDR2: begin
                    if (byte_end) begin
                        next_state = match_lo ? ST_RX : ST_IDLE;
                        next_ten_match = match_lo;
                    end
                end
                ST_TX: begin
                    if (byte_end && sda_in) begin
                        next_state = ST_IDLE;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    // rising edge: sample data, count bits
    always_ff @(posedge scl_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            ten_match <= 1'b0;
            start_seen <= 1'b0;
            bit_cnt <= CNT_ZERO;
            shift <= BYTE_ZERO;
            nine_done <= 1'b0;
            nine_event <= 1'b0;
        end else begin
            state <= next_state;
            ten_match <= next_ten_match;
            start_seen <= start_tog;
            nine_done <= byte_end && !new_frame && (state != ST_IDLE);
            nine_event <= byte_end && !new_frame && (addr_hit || rx_state || tx_state);
            if (new_frame) begin
                bit_cnt <= FIRST_BIT;
                shift <= {shift[6:0], sda_in};
            end else if (state == ST_IDLE || byte_end) begin
                bit_cnt <= CNT_ZERO;
            end else begin
                bit_cnt <= bit_cnt + FIRST_BIT;
                if (!tx_state) begin
                    shift <= {shift[6:0], sda_in};
                end
            end
        end
    end

    // falling edge: drive sda, raise events
    always_ff @(negedge scl_clk or negedge arst_n) begin
        if (!arst_n) begin
            sda_drive <= 1'b0;
            tx_lead <= 1'b0;
            hold_tog <= 1'b0;
            event_tog <= 1'b0;
            rx_tog <= 1'b0;
            rx_hold <= BYTE_ZERO;
        end else begin
            tx_lead <= nine_done && tx_state;
            if (nine_done && tx_state) begin
                hold_tog <= ~hold_tog;
            end
            if (nine_event) begin
                event_tog <= ~event_tog;
            end
            if (byte_end && rx_state) begin
                rx_hold <= shift;
                rx_tog <= ~rx_tog;
                sda_drive <= rx_ack;
            end else if (byte_end && !tx_state) begin
                sda_drive <= addr_hit;
            end else if (tx_state && !byte_end && (bit_cnt != CNT_ZERO)) begin
                sda_drive <= ~tx_word[tx_idx];
            end else begin
                sda_drive <= 1'b0;
            end
        end
    end

    // msb from the holding buffer settles while scl is held; writes must wait until the byte is under way
    assign sda_oe = tx_lead ? ~tx_buf[MSB_IDX] : sda_drive;
    assign sda_out = 1'b0;
    assign scl_out = 1'b0;
    // both toggles are registers and only one moves at a time, so no glitch
    assign scl_oe = hold_tog ^ rel_tog;

    // ************************************************************
    // core side
    // ************************************************************
    wire pending = hold_s ^ rel_tog;
    wire hold_new = hold_s ^ hold_prev;
    wire release_now = pending && clock_release && tx_full;
    wire rx_load = rx_p && !receive_buffer_full;
    wire ov_set = rx_p && receive_buffer_full;
    wire next_rbf = rx_load || (receive_buffer_full && !receive_buffer_read);
    wire next_ov = ov_set || (receive_overflow_flag && !overflow_clear);
    wire next_release = clock_release_bit || (clock_release && !hold_new && !release_now);
    wire next_tx_full = transmit_write || (tx_full && !release_now);
    assign clock_held = pending;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            receive_buffer <= BYTE_ZERO;
            receive_buffer_full <= 1'b0;
            receive_overflow_flag <= 1'b0;
            slave_event_flag <= 1'b0;
            tx_buf <= BYTE_ZERO;
            tx_word <= BYTE_ZERO;
            tx_full <= 1'b0;
            clock_release <= 1'b0;
            rel_tog <= 1'b0;
            hold_prev <= 1'b0;
        end else begin
            receive_buffer_full <= next_rbf;
            receive_overflow_flag <= next_ov;
            slave_event_flag <= event_p;
            tx_full <= next_tx_full;
            clock_release <= next_release;
            hold_prev <= hold_s;
            if (rx_load) begin
                receive_buffer <= rx_hold;
            end
            if (transmit_write) begin
                tx_buf <= transmit_holding_reg;
            end
            if (release_now) begin
                rel_tog <= hold_s;
                tx_word <= tx_buf;
            end
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    property p_rx_load;
        @(posedge mclk) disable iff (!arst_n)
        (rx_p && !receive_buffer_full) |=> (receive_buffer_full && receive_buffer == $past(rx_hold));
    endproperty
    a_rx_load: assert property (p_rx_load) else $error("byte not loaded into free buffer");
    property p_overflow_keep;
        @(posedge mclk) disable iff (!arst_n)
        (rx_p && receive_buffer_full) |=> ($stable(receive_buffer) && receive_overflow_flag);
    endproperty
    a_overflow_keep: assert property (p_overflow_keep) else $error("overflow changed buffer");
    property p_read_clears;
        @(posedge mclk) disable iff (!arst_n)
        (receive_buffer_full && receive_buffer_read && !rx_p) |=> !receive_buffer_full;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("full flag not cleared by read");
    property p_event_pulse;
        @(posedge mclk) disable iff (!arst_n)
        event_p |=> slave_event_flag ##1 !slave_event_flag;
    endproperty
    a_event_pulse: assert property (p_event_pulse) else $error("slave event not a single pulse");
    property p_hold_until_release;
        @(posedge mclk) disable iff (!arst_n)
        (pending && !(clock_release && tx_full)) |=> pending;
    endproperty
    a_hold_until_release: assert property (p_hold_until_release) else $error("clock released early");
    property p_hold_arrives;
        @(posedge mclk) disable iff (!arst_n)
        hold_new |-> (pending && scl_oe);
    endproperty
    a_hold_arrives: assert property (p_hold_arrives) else $error("stretch not held");
    property p_start_shift;
        @(posedge scl_clk) disable iff (!arst_n)
        new_frame |=> (state == ST_ADDR && bit_cnt == FIRST_BIT && shift[0] == $past(sda_in));
    endproperty
    a_start_shift: assert property (p_start_shift) else $error("start did not begin address");

    property p_seven_bit_dir;
        @(posedge scl_clk) disable iff (!arst_n)
        (state == ST_ADDR && byte_end && !cfg_mode && match7 && cfg_en && !new_frame)
            |=> (state == ($past(dir_read) ? ST_TX : ST_RX));
    endproperty
    a_seven_bit_dir: assert property (p_seven_bit_dir) else $error("wrong mode after 7-bit match");

    property p_ten_first_miss;
        @(posedge scl_clk) disable iff (!arst_n)
        (state == ST_ADDR && byte_end && cfg_mode && !match_hi && cfg_en && !new_frame)
            |=> (state == ST_IDLE && !ten_match);
    endproperty
    a_ten_first_miss: assert property (p_ten_first_miss) else $error("10-bit mismatch not idle");

    property p_ten_second_hit;
        @(posedge scl_clk) disable iff (!arst_n)
        (state == ST_ADDR2 && byte_end && match_lo && cfg_en && !new_frame) |=> (state == ST_RX && ten_match);
    endproperty
    a_ten_second_hit: assert property (p_ten_second_hit) else $error("10-bit match flag not set");

    property p_rx_ack;
        @(negedge scl_clk) disable iff (!arst_n)
        (byte_end && rx_state) |=> (sda_drive == $past(rx_ack));
    endproperty
    a_rx_ack: assert property (p_rx_ack) else $error("receive acknowledge wrong");
    c_rx_loaded: cover property (@(posedge mclk) disable iff (!arst_n) rx_load);
    c_overflow: cover property (@(posedge mclk) disable iff (!arst_n) ov_set);
    c_release: cover property (@(posedge mclk) disable iff (!arst_n) release_now);
    c_ten_match: cover property (@(posedge scl_clk) disable iff (!arst_n) $rose(ten_match));
endmodule

// ==== i2c_slave_address_match_tb.sv ====
// bench for the two-wire slave: master model on the wires, software pulses on the core side
// assumes the design carries its own timing assertions; outcomes at the ports are compared here
`timescale 1ns/1ps
module i2c_slave_address_match_tb;
    import i2c_slave_pkg::*;
    // ****************************************
    // wiring and helpers
    // ****************************************
    logic mclk, arst_n, scl_out, scl_oe, sda_out, sda_oe, module_enable_bit, ten_bit_address_mode, clock_held;
    logic transmit_write, clock_release_bit, receive_buffer_read, receive_buffer_full, receive_overflow_flag;
    logic overflow_clear, slave_event_flag, ten_bit_match_flag, scl_drv, sda_drv, stalled;
    logic [ADDR_W-1:0] slave_address_reg;
    logic [DATA_W-1:0] transmit_holding_reg, receive_buffer, ev_cnt;
    logic [3:0] sw_bus = 4'h0;
    int err_total = 0, n_checks = 0;
    // pull-ups: a released wire reads high
    wire scl_wire = scl_drv & (scl_oe ? scl_out : 1'h1);
    wire sda_wire = sda_drv & (sda_oe ? sda_out : 1'h1);
    assign {transmit_write, clock_release_bit, receive_buffer_read, overflow_clear} = sw_bus;
    i2c_slave_address_match dut_u (.mclk, .arst_n, .scl_clk(scl_wire), .scl_out, .scl_oe, .sda_in(sda_wire),
        .sda_out, .sda_oe, .module_enable_bit, .ten_bit_address_mode, .slave_address_reg, .transmit_holding_reg,
        .transmit_write, .clock_release_bit, .receive_buffer, .receive_buffer_read, .receive_buffer_full,
        .receive_overflow_flag, .overflow_clear, .slave_event_flag, .ten_bit_match_flag, .clock_held);
    i2c_master_model mst_u (.scl_drv, .sda_drv, .stalled, .scl_wire, .sda_wire);
    initial begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s, saw %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (err_total == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge mclk) ev_cnt <= (arst_n !== 1'h1) ? 8'h00 : ev_cnt + 8'(slave_event_flag === 1'h1);
    always @(sda_oe) if (arst_n === 1'h1) chk(8'(scl_wire), 8'h00, "sda moved, scl high");
    always @(posedge stalled) begin
        chk(8'h01, 8'h00, "scl stuck low");
        complete_run();
    end
    task automatic sw(input logic [3:0] m);
        @(negedge mclk) sw_bus = m;
        @(negedge mclk) sw_bus = 4'h0;
    endtask
    // ae holds the expected acknowledge and the expected event count
    task automatic wr(input logic [7:0] d, input logic [1:0] ae);
        logic ack;
        logic [7:0] ev0;
        ev0 = ev_cnt;
        mst_u.write_byte(d, ack);
        repeat (8) @(negedge mclk);
        chk({ack, 7'(ev_cnt - ev0)}, {ae[1], 6'h00, ae[0]}, "ack, events");
    endtask
    task automatic aw(input logic [7:0] d, input logic [1:0] ae);
        mst_u.start();
        wr(d, ae);
    endtask
    task automatic tx(input logic [7:0] d, input logic ack_in);
        logic [7:0] got, ev0;
        chk(8'({scl_oe, clock_held}), 8'h03, "stretch");
        transmit_holding_reg = d;
        sw(4'h8);
        repeat (10) @(negedge mclk);
        chk(8'(scl_oe), 8'h01, "held before release");
        sw(4'h4);
        repeat (5) @(negedge mclk);
        chk(8'(scl_oe), 8'h00, "released");
        ev0 = ev_cnt;
        mst_u.read_byte(ack_in, got);
        repeat (8) @(negedge mclk);
        chk(got, d, "sent byte");
        chk({scl_oe, 7'(ev_cnt - ev0)}, {ack_in, 7'h01}, "restretch, event");
    endtask
    initial begin
        arst_n = 1'h0;
        module_enable_bit = 1'h0;
        ten_bit_address_mode = 1'h0;
        slave_address_reg = 10'h02A;
        transmit_holding_reg = 8'h00;
        repeat (12) @(negedge mclk);
        chk({2'h0, scl_oe, sda_oe, receive_buffer_full, receive_overflow_flag, slave_event_flag,
            ten_bit_match_flag}, 8'h00, "reset");
        arst_n = 1'h1;
        aw(8'h54, 2'h0);
        mst_u.stop();
        @(negedge mclk) module_enable_bit = 1'h1;
        mst_u.idle_clocks(3);
        aw(8'h54, 2'h3);
        chk(8'(receive_buffer_full), 8'h00, "full after address");
        wr(8'h55, 2'h3);
        chk(receive_buffer, 8'h55, "byte loaded");
        chk(8'(receive_buffer_full), 8'h01, "full set");
        wr(8'hA3, 2'h1);
        chk(receive_buffer, 8'h55, "kept on overflow");
        chk(8'({receive_buffer_full, receive_overflow_flag}), 8'h03, "full, overflow");
        sw(4'h2);
        chk(8'(receive_buffer_full), 8'h00, "read clears full");
        wr(8'h3C, 2'h1);
        chk(receive_buffer, 8'h3C, "load with overflow");
        sw(4'h3);
        wr(8'h81, 2'h3);
        mst_u.stop();
        aw(8'h56, 2'h0);
        wr(8'h11, 2'h0);
        mst_u.stop();
        aw(8'h55, 2'h3);
        chk(receive_buffer, 8'h81, "address kept buffer");
        tx(8'hC6, 1'h1);
        tx(8'h39, 1'h0);
        mst_u.stop();
        sw(4'h2);
        ten_bit_address_mode = 1'h1;
        slave_address_reg = 10'h2D5;
        aw(8'hF4, 2'h3);
        wr(8'hD5, 2'h3);
        chk(8'(ten_bit_match_flag), 8'h01, "full match");
        wr(8'h5A, 2'h3);
        chk(receive_buffer, 8'h5A, "ten-bit data");
        aw(8'hF5, 2'h3);
        tx(8'h96, 1'h0);
        mst_u.stop();
        aw(8'hF4, 2'h3);
        chk(8'(ten_bit_match_flag), 8'h00, "partial clears");
        wr(8'hD4, 2'h0);
        mst_u.stop();
        aw(8'hF6, 2'h0);
        mst_u.stop();
        aw(8'hF5, 2'h0);
        mst_u.stop();
        complete_run();
    end
endmodule

// ==== i2c_slave_pkg.sv ====
// shared constants and types of the two-wire slave block
// assumes an 8-bit byte stream and a 10-bit stored slave address
package i2c_slave_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int CNT_W = 4;
    localparam int CFG_W = ADDR_W + 4;

    // ************************************************************
    // framing constants
    // ************************************************************
    localparam logic [CNT_W-1:0] BYTE_BITS = 4'h8;
    localparam logic [CNT_W-1:0] FIRST_BIT = 4'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [2:0] MSB_IDX = 3'h7;
    localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

    // ************************************************************
    // link state machine
    // ************************************************************
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_ADDR  = 5'h02,
        ST_ADDR2 = 5'h04,
        ST_RX    = 5'h08,
        ST_TX    = 5'h10
    } link_state_e;

endpackage

// ==== level_sync.sv ====
// two-flop synchroniser for quasi-static levels
// assumes each bit is sampled independently; multi-bit words must be stable when read
`timescale 1ns/1ps
module level_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // meta is read by q only
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// ==== toggle_pulse.sv ====
// toggle-to-pulse event crossing, one lane per bit
// assumes the source toggles no faster than every third destination edge
`timescale 1ns/1ps
module toggle_pulse #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] tog,
    output logic [WIDTH-1:0] pulse
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= '0;
            sync <= '0;
            prev <= '0;
        end else begin
            meta <= tog;
            sync <= meta;
            prev <= sync;
        end
    end

    assign pulse = sync ^ prev;
endmodule
